// [src/pcpp_top.sv]
`timescale 1ns/1ps
// Function
// - Serial bits shift in only while serial load strobe is low.
// - Rising serial load or hop strobe copies primary into secondary.
// - Shift clock rise shifts into primary, or enhancement when its write is high.
// - Serial mode: bank pick 1 uses primary, 0 uses secondary.
// - Parallel mode: bank pick 1 uses primary, 0 uses secondary.
// - Prescaler enable active low; high routes VCO around prescaler.
// - Parallel mode: enhancement write rise captures bus into enhancement register.
// - High nibble strobe rise loads bus[3:0] into ref[5:4], main[8:7].
// - Low byte strobe rise loads bus into prescaler bit, main[6:0].
// - Swallow strobe rise loads bus into ref[3:0], swallow[3:0].
// - Direct select 1 gives direct mode; else serial select picks serial/parallel.
// - Direct mode takes main[6:0] and four-bit swallow count from pins.
// - Parallel bus is eight bits, bit zero least significant.
// - Enhancement bits act only while enhancement enable is low.
module pcpp_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic serial_load_n,
   input wire logic hop_strobe,
   input wire logic enh_write,
   input wire logic main_low_byte_strobe,
   input wire logic main_high_nibble_strobe,
   input wire logic swallow_strobe,
   input wire logic serial_bank_pick,
   input wire logic parallel_bank_pick,
   input wire logic serial_select,
   input wire logic direct_select,
   input wire logic enh_enable_n,
   input wire logic [7:0] pbus,
   input wire logic [5:0] direct_ref,
   output logic [8:0] main_count,
   output logic [5:0] ref_count,
   output logic [3:0] swallow_count,
   output logic prescaler_bypass,
   output logic [7:0] enh_bits,
   output logic [1:0] mode
);

   // ------------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------------
   logic [pcpp_pkg::PIN_W-1:0] pins;
   logic [pcpp_pkg::PIN_W-1:0] lvl;
   logic [pcpp_pkg::PIN_W-1:0] rise;

   assign pins = {direct_ref, pbus, enh_enable_n, direct_select, serial_select,
                  parallel_bank_pick, serial_bank_pick, swallow_strobe,
                  main_high_nibble_strobe, main_low_byte_strobe, enh_write,
                  hop_strobe, serial_load_n, sdata, sclk};

   pcpp_sync #(.W(pcpp_pkg::PIN_W)) u_sync (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .d(pins),
      .lvl(lvl),
      .rise(rise)
   );

   wire logic [7:0] bus_s = lvl[pcpp_pkg::P_BUS +: 8];
   wire logic [5:0] dref_s = lvl[pcpp_pkg::P_DREF +: 6];

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------
   pcpp_pkg::pcpp_mode_e mode_r;
   pcpp_pkg::pcpp_mode_e mode_nxt;

   assign mode_nxt = lvl[pcpp_pkg::P_DSEL] ? pcpp_pkg::MODE_DIRECT :
                     lvl[pcpp_pkg::P_SSEL] ? pcpp_pkg::MODE_SERIAL :
                     pcpp_pkg::MODE_PARALLEL;

   wire logic is_ser = (mode_r == pcpp_pkg::MODE_SERIAL);
   wire logic is_par = (mode_r == pcpp_pkg::MODE_PARALLEL);

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   // Serial shifting is gated by the load strobe level so that a host
   // toggling the shift clock between frames cannot disturb the word.
   wire logic shift_ok = is_ser & rise[pcpp_pkg::P_SCLK] & ~lvl[pcpp_pkg::P_SLOAD_N];
   wire logic shift_prim = shift_ok & ~lvl[pcpp_pkg::P_EWR];
   wire logic shift_enh = shift_ok & lvl[pcpp_pkg::P_EWR];
   wire logic wr_enh_par = is_par & rise[pcpp_pkg::P_EWR];
   wire logic wr_mhigh = is_par & rise[pcpp_pkg::P_MHIGH];
   wire logic wr_mlow = is_par & rise[pcpp_pkg::P_MLOW];
   wire logic wr_swl = is_par & rise[pcpp_pkg::P_SWL];
   wire logic xfer = rise[pcpp_pkg::P_SLOAD_N] | rise[pcpp_pkg::P_HOP];

   // ------------------------------------------------------------------
   // Primary, secondary and enhancement registers
   // ------------------------------------------------------------------
   logic [19:0] prim_r;
   logic [19:0] prim_nxt;
   logic [19:0] sec_r;
   logic [7:0] enh_r;
   logic [7:0] enh_nxt;

   always_comb begin
      prim_nxt = prim_r;
      if (shift_prim) begin
         prim_nxt = {prim_r[18:0], lvl[pcpp_pkg::P_SDATA]};
      end
      if (wr_mhigh) begin
         prim_nxt[pcpp_pkg::F_REF_HI +: 2] = bus_s[3:2];
         prim_nxt[pcpp_pkg::F_MAIN_HI +: 2] = bus_s[1:0];
      end
      if (wr_mlow) begin
         prim_nxt[pcpp_pkg::F_PRE] = bus_s[7];
         prim_nxt[pcpp_pkg::F_MAIN_LO +: 7] = bus_s[6:0];
      end
      if (wr_swl) begin
         prim_nxt[pcpp_pkg::F_REF_LO +: 4] = bus_s[7:4];
         prim_nxt[pcpp_pkg::F_SWL +: 4] = bus_s[3:0];
      end
   end

   assign enh_nxt = shift_enh ? {enh_r[6:0], lvl[pcpp_pkg::P_SDATA]} :
                    wr_enh_par ? bus_s : enh_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prim_r <= pcpp_pkg::PRIM_RST;
         enh_r <= pcpp_pkg::ENH_RST;
         mode_r <= pcpp_pkg::MODE_DIRECT;
      end else if (clk_en) begin
         prim_r <= prim_nxt;
         enh_r <= enh_nxt;
         mode_r <= mode_nxt;
      end
   end

   // A transfer takes the primary word as it stood before any write of
   // the same cycle, so a strobe coinciding with a hop never half-lands.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_r <= pcpp_pkg::PRIM_RST;
      end else if (clk_en && xfer) begin
         sec_r <= prim_r;
      end
   end

   // ------------------------------------------------------------------
   // Counter source selection
   // ------------------------------------------------------------------
   // In direct mode the swallow bits share pins with the parallel-mode
   // controls; the main high bits have no pin and read as zero.
   wire logic [3:0] dir_swl = {lvl[pcpp_pkg::P_SSEL], lvl[pcpp_pkg::P_MHIGH],
                               lvl[pcpp_pkg::P_EWR], lvl[pcpp_pkg::P_PBANK]};
   wire logic pick_prim = is_ser ? lvl[pcpp_pkg::P_SBANK] : lvl[pcpp_pkg::P_PBANK];
   wire logic [19:0] word_sel = pick_prim ? prim_r : sec_r;

   logic [8:0] main_sel;
   logic [5:0] ref_sel;
   logic [3:0] swl_sel;
   logic pre_sel;

   always_comb begin
      unique case (mode_r)
         pcpp_pkg::MODE_DIRECT: begin
            main_sel = {2'h0, bus_s[6:0]};
            ref_sel = dref_s;
            swl_sel = dir_swl;
            pre_sel = bus_s[7];
         end
         pcpp_pkg::MODE_SERIAL, pcpp_pkg::MODE_PARALLEL: begin
            main_sel = pcpp_pkg::pcpp_main(word_sel);
            ref_sel = pcpp_pkg::pcpp_ref(word_sel);
            swl_sel = pcpp_pkg::pcpp_swl(word_sel);
            pre_sel = word_sel[pcpp_pkg::F_PRE];
         end
         default: begin
            main_sel = 9'h000;
            ref_sel = 6'h00;
            swl_sel = 4'h0;
            pre_sel = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------------
   logic [8:0] main_r;
   logic [5:0] ref_r;
   logic [3:0] swl_r;
   logic byp_r;
   logic [7:0] enh_out_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         main_r <= 9'h000;
         ref_r <= 6'h00;
         swl_r <= 4'h0;
         byp_r <= 1'b0;
         enh_out_r <= pcpp_pkg::ENH_RST;
      end else if (clk_en) begin
         main_r <= main_sel;
         ref_r <= ref_sel;
         swl_r <= swl_sel;
         byp_r <= pre_sel;
         enh_out_r <= lvl[pcpp_pkg::P_ENH_N] ? 8'h00 : enh_r;
      end
   end

   assign main_count = main_r;
   assign ref_count = ref_r;
   assign swallow_count = swl_r;
   assign prescaler_bypass = byp_r;
   assign enh_bits = enh_out_r;
   assign mode = mode_r;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_shift_prim;
      clk_en && shift_prim;
   endsequence

   sequence s_shift_enh;
      clk_en && shift_enh;
   endsequence

   sequence s_xfer;
      clk_en && xfer;
   endsequence

   a_shift_primary: assert property (@(posedge clk) disable iff (rst)
      s_shift_prim |=> prim_r == {$past(prim_r[18:0]), $past(lvl[pcpp_pkg::P_SDATA])})
      else $error("primary shift wrong");

   a_shift_enh_reg: assert property (@(posedge clk) disable iff (rst)
      s_shift_enh |=> enh_r == {$past(enh_r[6:0]), $past(lvl[pcpp_pkg::P_SDATA])}
         && $stable(prim_r))
      else $error("enhancement shift wrong");

   a_load_high_hold: assert property (@(posedge clk) disable iff (rst)
      (clk_en && is_ser && lvl[pcpp_pkg::P_SLOAD_N]) |=> $stable(prim_r) && $stable(enh_r))
      else $error("shift taken while load high");

   a_hop_copy: assert property (@(posedge clk) disable iff (rst)
      s_xfer |=> sec_r == $past(prim_r))
      else $error("secondary not loaded");

   a_sec_hold: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !xfer) |=> $stable(sec_r))
      else $error("secondary changed without transfer");

   a_serial_bank: assert property (@(posedge clk) disable iff (rst)
      (clk_en && is_ser) |=> main_count == pcpp_pkg::pcpp_main($past(
         lvl[pcpp_pkg::P_SBANK] ? prim_r : sec_r)))
      else $error("serial bank selection wrong");

   a_parallel_bank: assert property (@(posedge clk) disable iff (rst)
      (clk_en && is_par) |=> ref_count == pcpp_pkg::pcpp_ref($past(
         lvl[pcpp_pkg::P_PBANK] ? prim_r : sec_r)))
      else $error("parallel bank selection wrong");

   a_bypass_bit: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !is_ser && !is_par) |=> prescaler_bypass == $past(bus_s[7]))
      else $error("bypass not following pin");

   a_enh_parallel: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_enh_par) |=> enh_r == $past(bus_s))
      else $error("enhancement capture wrong");

   a_high_nibble: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_mhigh) |=> prim_r[19:16] == $past(bus_s[3:0]))
      else $error("high nibble capture wrong");

   a_low_byte: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_mlow) |=> prim_r[15:8] == $past(bus_s))
      else $error("low byte capture wrong");

   a_swallow_byte: assert property (@(posedge clk) disable iff (rst)
      (clk_en && wr_swl) |=> prim_r[7:0] == $past(bus_s))
      else $error("swallow byte capture wrong");

   a_mode_decode: assert property (@(posedge clk) disable iff (rst)
      (clk_en && lvl[pcpp_pkg::P_DSEL]) |=> mode_r == pcpp_pkg::MODE_DIRECT)
      else $error("direct mode not taken");

   a_mode_serial: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !lvl[pcpp_pkg::P_DSEL] && lvl[pcpp_pkg::P_SSEL]) |=>
         mode_r == pcpp_pkg::MODE_SERIAL)
      else $error("serial mode not taken");

   a_mode_parallel: assert property (@(posedge clk) disable iff (rst)
      (clk_en && !lvl[pcpp_pkg::P_DSEL] && !lvl[pcpp_pkg::P_SSEL]) |=>
         mode_r == pcpp_pkg::MODE_PARALLEL)
      else $error("parallel mode not taken");

   a_direct_swl: assert property (@(posedge clk) disable iff (rst)
      (clk_en && mode_r == pcpp_pkg::MODE_DIRECT) |=> swallow_count == $past(dir_swl))
      else $error("direct swallow wrong");

   a_enh_gate: assert property (@(posedge clk) disable iff (rst)
      (clk_en && lvl[pcpp_pkg::P_ENH_N]) |=> enh_bits == 8'h00)
      else $error("enhancement not gated");

endmodule : pcpp_top

// [src/pcpp_pkg.sv]
package pcpp_pkg;

   // ------------------------------------------------------------------
   // Register widths and reset values
   // ------------------------------------------------------------------
   localparam int PRIM_W = 20;
   localparam int ENH_W = 8;
   localparam int BUS_W = 8;
   localparam int MAIN_W = 9;
   localparam int REF_W = 6;
   localparam int SWL_W = 4;
   localparam logic [19:0] PRIM_RST = 20'h00000;
   localparam logic [7:0] ENH_RST = 8'h00;

   // ------------------------------------------------------------------
   // Primary word layout, high nibble group first as it is shifted in
   // ------------------------------------------------------------------
   localparam int F_REF_HI = 18;
   localparam int F_MAIN_HI = 16;
   localparam int F_PRE = 15;
   localparam int F_MAIN_LO = 8;
   localparam int F_REF_LO = 4;
   localparam int F_SWL = 0;

   // ------------------------------------------------------------------
   // Bit positions of the sampled pin vector
   // ------------------------------------------------------------------
   localparam int P_SCLK = 0;
   localparam int P_SDATA = 1;
   localparam int P_SLOAD_N = 2;
   localparam int P_HOP = 3;
   localparam int P_EWR = 4;
   localparam int P_MLOW = 5;
   localparam int P_MHIGH = 6;
   localparam int P_SWL = 7;
   localparam int P_SBANK = 8;
   localparam int P_PBANK = 9;
   localparam int P_SSEL = 10;
   localparam int P_DSEL = 11;
   localparam int P_ENH_N = 12;
   localparam int P_BUS = 13;
   localparam int P_DREF = 21;
   localparam int PIN_W = 27;

   typedef enum logic [1:0] {MODE_DIRECT, MODE_SERIAL, MODE_PARALLEL} pcpp_mode_e;

   function automatic logic [8:0] pcpp_main(input logic [19:0] w);
      pcpp_main = {w[F_MAIN_HI +: 2], w[F_MAIN_LO +: 7]};
   endfunction : pcpp_main

   function automatic logic [5:0] pcpp_ref(input logic [19:0] w);
      pcpp_ref = {w[F_REF_HI +: 2], w[F_REF_LO +: 4]};
   endfunction : pcpp_ref

   function automatic logic [3:0] pcpp_swl(input logic [19:0] w);
      pcpp_swl = w[F_SWL +: 4];
   endfunction : pcpp_swl

endpackage : pcpp_pkg

// [src/pcpp_sync.sv]
`timescale 1ns/1ps
module pcpp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise
);

   logic [W-1:0] meta_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] prev_r;
   logic [1:0] warm_r;
   logic armed;

   // ------------------------------------------------------------------
   // Edge finding warm-up
   // ------------------------------------------------------------------
   // Edges are held back until the third flop carries a real pin level,
   // so a pin that idles high cannot fake a rise just after reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         warm_r <= 2'h0;
      end else if (clk_en && !armed) begin
         warm_r <= warm_r + 2'h1;
      end
   end

   assign armed = (warm_r == 2'h3);

   // ------------------------------------------------------------------
   // Two-flop synchroniser per pin, third flop for edge finding
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_r[i] <= 1'b0;
               lvl_r[i] <= 1'b0;
               prev_r[i] <= 1'b0;
            end else if (clk_en) begin
               meta_r[i] <= d[i];
               lvl_r[i] <= meta_r[i];
               prev_r[i] <= lvl_r[i];
            end
         end
         assign rise[i] = lvl_r[i] & ~prev_r[i] & armed;
      end
   endgenerate

   assign lvl = lvl_r;

endmodule : pcpp_sync

// [test/pcpp_host_model.sv]
`timescale 1ns/1ps
module pcpp_host_model #(
   parameter int HALF = 16
) (
   input wire logic clk,
   output logic sclk,
   output logic sdata,
   output logic serial_load_n,
   output logic enh_write
);
   // ---------------------------------------------
   // Serial host
   // ---------------------------------------------
   // The half period counts system clocks, so a slower host is one parameter away.
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      serial_load_n = 1'b1;
      enh_write = 1'b0;
   end

   task automatic send(input logic [19:0] w, input int n, input logic enh);
      @(posedge clk);
      enh_write <= enh;
      serial_load_n <= 1'b0;
      repeat (HALF) @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         sdata <= w[i];
         repeat (HALF) @(posedge clk);
         sclk <= 1'b1;
         repeat (HALF) @(posedge clk);
         sclk <= 1'b0;
      end
      // A released data line shows the inverse of its last bit, never a held value.
      sdata <= ~w[0];
      repeat (HALF) @(posedge clk);
      serial_load_n <= 1'b1;
      enh_write <= 1'b0;
      repeat (HALF) @(posedge clk);
   endtask : send
endmodule : pcpp_host_model

// [test/pcpp_top_tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module pcpp_top_tb_top;
   typedef struct {
      int sel;
      logic [7:0] d;
      logic [8:0] m;
      logic [5:0] r;
      logic [3:0] s;
      logic b;
      logic [7:0] e;
   } pcpp_row_s;

   pcpp_row_s rows [4] = '{
      '{2, 8'hA5, 9'h000, 6'h0A, 4'h5, 1'b0, 8'h00},
      '{1, 8'hFB, 9'h180, 6'h2A, 4'h5, 1'b0, 8'h00},
      '{0, 8'h9C, 9'h19C, 6'h2A, 4'h5, 1'b1, 8'h00},
      '{3, 8'h3E, 9'h19C, 6'h2A, 4'h5, 1'b1, 8'h3E}};
   int error_cnt = 0;
   int tests_run = 0;
   logic clk, rst, clk_en, hop, tb_ew, h_ew, mlow, mhigh, swl_s;
   logic sbank, pbank, ssel, dsel, enh_n, sclk, sdata, sload_n;
   logic [7:0] pbus;
   logic [5:0] dref;
   logic [8:0] main_count;
   logic [5:0] ref_count;
   logic [3:0] swallow_count;
   logic prescaler_bypass;
   logic [7:0] enh_bits;
   logic [1:0] mode;
   wire logic ew = tb_ew | h_ew;

   pcpp_top pcpp_top_i (.clk(clk), .rst(rst), .clk_en(clk_en), .sclk(sclk), .sdata(sdata),
      .serial_load_n(sload_n), .hop_strobe(hop), .enh_write(ew),
      .main_low_byte_strobe(mlow), .main_high_nibble_strobe(mhigh),
      .swallow_strobe(swl_s), .serial_bank_pick(sbank), .parallel_bank_pick(pbank),
      .serial_select(ssel), .direct_select(dsel), .enh_enable_n(enh_n), .pbus(pbus),
      .direct_ref(dref), .main_count(main_count), .ref_count(ref_count),
      .swallow_count(swallow_count), .prescaler_bypass(prescaler_bypass),
      .enh_bits(enh_bits), .mode(mode));

   pcpp_host_model pcpp_host_model_i (.clk(clk), .sclk(sclk), .sdata(sdata),
      .serial_load_n(sload_n), .enh_write(h_ew));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic chk_all(input logic [8:0] m, input logic [5:0] r, input logic [3:0] s,
         input logic b);
      `CHK(main_count, m)
      `CHK(ref_count, r)
      `CHK(swallow_count, s)
      `CHK(prescaler_bypass, b)
   endtask : chk_all

   task automatic pstrobe(input int id, input logic [7:0] d);
      pbus <= d;
      tick(4);
      case (id)
         0: mlow <= 1'b1;
         1: mhigh <= 1'b1;
         2: swl_s <= 1'b1;
         default: tb_ew <= 1'b1;
      endcase
      tick(4);
      {mlow, mhigh, swl_s, tb_ew} <= 4'h0;
      tick(8);
   endtask : pstrobe

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      tick(20000);
      error_cnt++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {rst, clk_en, hop, tb_ew, mlow, mhigh, swl_s} = 7'h60;
      {sbank, pbank, ssel, dsel, enh_n} = 5'h08;
      pbus = 8'h00;
      dref = 6'h00;
      tick(5);
      #1 chk_all(9'h000, 6'h00, 4'h0, 1'b0);
      `CHK(mode, pcpp_pkg::MODE_DIRECT)
      tick(5);
      rst <= 1'b0;
      tick(8);
      `CHK(mode, pcpp_pkg::MODE_PARALLEL)
      // Rows build up the primary word field by field, so each row sees the earlier ones.
      foreach (rows[i]) begin
         pstrobe(rows[i].sel, rows[i].d);
         chk_all(rows[i].m, rows[i].r, rows[i].s, rows[i].b);
         `CHK(enh_bits, rows[i].e)
      end
      enh_n <= 1'b1;
      tick(8);
      `CHK(enh_bits, 8'h00)
      enh_n <= 1'b0;
      pbank <= 1'b0;
      tick(8);
      chk_all(9'h000, 6'h00, 4'h0, 1'b0);
      hop <= 1'b1;
      tick(8);
      hop <= 1'b0;
      chk_all(9'h19C, 6'h2A, 4'h5, 1'b1);
      pstrobe(0, 8'h01);
      chk_all(9'h19C, 6'h2A, 4'h5, 1'b1);
      pbank <= 1'b1;
      tick(8);
      chk_all(9'h181, 6'h2A, 4'h5, 1'b0);
      ssel <= 1'b1;
      sbank <= 1'b1;
      tick(8);
      `CHK(mode, pcpp_pkg::MODE_SERIAL)
      pcpp_host_model_i.send(20'h5A3C7, 20, 1'b0);
      tick(8);
      chk_all(9'h0A3, 6'h1C, 4'h7, 1'b1);
      sbank <= 1'b0;
      tick(8);
      chk_all(9'h0A3, 6'h1C, 4'h7, 1'b1);
      pcpp_host_model_i.send(20'h000B6, 8, 1'b1);
      tick(8);
      `CHK(enh_bits, 8'hB6)
      chk_all(9'h0A3, 6'h1C, 4'h7, 1'b1);
      dsel <= 1'b1;
      tick(8);
      `CHK(mode, pcpp_pkg::MODE_DIRECT)
      pbus <= 8'hD3;
      dref <= 6'h2D;
      {ssel, mhigh, tb_ew, pbank} <= 4'hA;
      tick(8);
      chk_all(9'h053, 6'h2D, 4'hA, 1'b1);
      // A low clock enable must freeze the pin samplers as well as the outputs.
      clk_en <= 1'b0;
      pbus <= 8'h2C;
      tick(8);
      chk_all(9'h053, 6'h2D, 4'hA, 1'b1);
      clk_en <= 1'b1;
      tick(8);
      chk_all(9'h02C, 6'h2D, 4'hA, 1'b0);
      rst <= 1'b1;
      tick(2);
      chk_all(9'h000, 6'h00, 4'h0, 1'b0);
      `CHK(enh_bits, 8'h00)
      end_sim();
   end
endmodule : pcpp_top_tb_top
